//--- rtl/fsw_write_guard.sv
// flash section write guard: section checks, page buffer, lock and protect bits
`timescale 1ns/1ns
// Functional notes
// - flash commits always cover a whole page
// - boundaries are fuse times 256, boot at zero
// - boot fuse zero makes all flash boot
// - code fuse zero: code section to flash end
// - code fuse not above boot: no code section
// - otherwise code between boundaries, data after
// - boundary past flash end uses fuse default
// - vectors at code start, boot when selected
// - boot code may write code and data
// - code may write data, never boot
// - data-section code may write nothing
// - boot section never written by the cpu
// - boot lock blocks boot reads after leaving
// - code protect bit stops code section updates
// - eeprom updates only marked bytes
// - buffer store ands new and old byte
module fsw_write_guard (
   input wire logic clk_sys_in,
   input wire logic sys_rst_in,
   input wire logic [7:0] boot_end_fuse_in,
   input wire logic [7:0] code_end_fuse_in,
   input wire logic [fsw_pkg::ADDR_W-1:0] cpu_pc_in,
   input fsw_pkg::fsw_store_s cpu_st_in,
   input wire logic cpu_rd_valid_in,
   input wire logic [fsw_pkg::ADDR_W-1:0] cpu_rd_addr_in,
   input wire logic [7:0] s_axi_awaddr_in,
   input wire logic s_axi_awvalid_in,
   output logic s_axi_awready_out,
   input wire logic [31:0] s_axi_wdata_in,
   input wire logic [3:0] s_axi_wstrb_in,
   input wire logic s_axi_wvalid_in,
   output logic s_axi_wready_out,
   output logic [1:0] s_axi_bresp_out,
   output logic s_axi_bvalid_out,
   input wire logic s_axi_bready_in,
   input wire logic [7:0] s_axi_araddr_in,
   input wire logic s_axi_arvalid_in,
   output logic s_axi_arready_out,
   output logic [31:0] s_axi_rdata_out,
   output logic [1:0] s_axi_rresp_out,
   output logic s_axi_rvalid_out,
   input wire logic s_axi_rready_in,
   output logic st_refused_out,
   output logic rd_blocked_out,
   output logic [fsw_pkg::ADDR_W-1:0] vector_base_out,
   output fsw_pkg::fsw_commit_s commit_out,
   output fsw_pkg::fsw_buf_t page_buf_out
);
   logic [7:0] boot_fuse_reg;
   logic [7:0] code_fuse_reg;
   logic [7:0] eff_boot;
   logic [7:0] eff_code;
   fsw_pkg::fsw_section_e pc_sec;
   fsw_pkg::fsw_section_e st_sec;
   fsw_pkg::fsw_section_e rd_sec;
   logic st_permit;
   logic st_take;
   logic boot_lock_reg;
   logic lock_armed_reg;
   logic cwp_reg;
   logic vsel_reg;
   logic refused_sticky_reg;
   logic [7:0] aw_addr_reg;
   logic [31:0] w_data_reg;
   logic [3:0] w_strb_reg;
   logic wr_fire;
   logic cmd_go;
   logic commit_ok;
   logic buf_clear;
   logic [fsw_pkg::PAGE_BYTES-1:0] mark_reg;
   logic buf_ee_reg;
   logic [fsw_pkg::PAGE_W-1:0] buf_page_reg;
   logic [fsw_pkg::IDX_W-1:0] st_idx;
   logic [31:0] rd_word;

   // fuses are static while running; sampled only while reset is held
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         boot_fuse_reg <= boot_end_fuse_in;
         code_fuse_reg <= code_end_fuse_in;
      end
   end

   fsw_section_map u_pc_map (
      .boot_end_fuse_in(boot_fuse_reg),
      .code_end_fuse_in(code_fuse_reg),
      .addr_in(cpu_pc_in),
      .section_out(pc_sec),
      .boot_end_out(eff_boot),
      .code_end_out(eff_code)
   );

   fsw_section_map u_st_map (
      .boot_end_fuse_in(boot_fuse_reg),
      .code_end_fuse_in(code_fuse_reg),
      .addr_in(cpu_st_in.addr),
      .section_out(st_sec),
      .boot_end_out(),
      .code_end_out()
   );

   fsw_section_map u_rd_map (
      .boot_end_fuse_in(boot_fuse_reg),
      .code_end_fuse_in(code_fuse_reg),
      .addr_in(cpu_rd_addr_in),
      .section_out(rd_sec),
      .boot_end_out(),
      .code_end_out()
   );

   // directional write protection, decided from the live pc
   always_comb begin
      st_permit = 1'b0;
      if (pc_sec != fsw_pkg::SEC_DATA) begin
         if (cpu_st_in.eeprom) begin
            st_permit = 1'b1;
         end else begin
            unique case (st_sec)
               fsw_pkg::SEC_BOOT: st_permit = 1'b0;
               fsw_pkg::SEC_CODE: st_permit = (pc_sec == fsw_pkg::SEC_BOOT) && !cwp_reg;
               fsw_pkg::SEC_DATA: st_permit = 1'b1;
               default: st_permit = 1'b0;
            endcase
         end
      end
   end

   assign st_take = cpu_st_in.valid && st_permit;
   assign st_idx = cpu_st_in.addr[fsw_pkg::IDX_W-1:0];

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         st_refused_out <= 1'b0;
      end else begin
         st_refused_out <= cpu_st_in.valid && !st_permit;
      end
   end

   // page buffer: each byte erased to ones, stores and into it
   for (genvar i = 0; i < fsw_pkg::PAGE_BYTES; i++) begin : g_buf
      always_ff @(posedge clk_sys_in) begin
         if (sys_rst_in || buf_clear) begin
            page_buf_out[i] <= fsw_pkg::BYTE_ERASED;
            mark_reg[i] <= 1'b0;
         end else if (st_take && (int'(st_idx) == i)) begin
            page_buf_out[i] <= page_buf_out[i] & cpu_st_in.data;
            mark_reg[i] <= 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         buf_ee_reg <= 1'b0;
         buf_page_reg <= '0;
      end else if (st_take) begin
         buf_ee_reg <= cpu_st_in.eeprom;
         buf_page_reg <= cpu_st_in.addr[fsw_pkg::ADDR_W-1:fsw_pkg::IDX_W];
      end
   end

   // commit: an empty buffer has no page address, so the command is dropped
   assign cmd_go = wr_fire && (aw_addr_reg == fsw_pkg::REG_CMD) && w_strb_reg[0];
   assign commit_ok = cmd_go && (mark_reg != '0) &&
      ((w_data_reg[2:0] == fsw_pkg::CMD_WRITE) || (w_data_reg[2:0] == fsw_pkg::CMD_ERASE) ||
       (w_data_reg[2:0] == fsw_pkg::CMD_ERWR));
   assign buf_clear = commit_ok || (cmd_go && (w_data_reg[2:0] == fsw_pkg::CMD_CLEAR));

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         commit_out <= '0;
      end else begin
         commit_out.valid <= commit_ok;
         if (commit_ok) begin
            commit_out.erase <= w_data_reg[2:0] != fsw_pkg::CMD_WRITE;
            commit_out.write <= w_data_reg[2:0] != fsw_pkg::CMD_ERASE;
            commit_out.eeprom <= buf_ee_reg;
            commit_out.page <= buf_page_reg;
            // flash never takes a partial page; eeprom only marked bytes
            commit_out.mask <= buf_ee_reg ? mark_reg : '1;
         end
      end
   end

   // lock and protect bits are one-way until reset
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         boot_lock_reg <= 1'b0;
         cwp_reg <= 1'b0;
         vsel_reg <= 1'b0;
      end else if (wr_fire && (aw_addr_reg == fsw_pkg::REG_CTRL) && w_strb_reg[0]) begin
         if (w_data_reg[fsw_pkg::CTRL_LOCK] && (pc_sec == fsw_pkg::SEC_BOOT)) begin
            boot_lock_reg <= 1'b1;
         end
         if (w_data_reg[fsw_pkg::CTRL_CWP]) begin
            cwp_reg <= 1'b1;
         end
         vsel_reg <= w_data_reg[fsw_pkg::CTRL_VSEL];
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         lock_armed_reg <= 1'b0;
      end else if (boot_lock_reg && (pc_sec != fsw_pkg::SEC_BOOT)) begin
         lock_armed_reg <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         rd_blocked_out <= 1'b0;
      end else begin
         rd_blocked_out <= lock_armed_reg && ((cpu_rd_valid_in && rd_sec == fsw_pkg::SEC_BOOT) ||
            pc_sec == fsw_pkg::SEC_BOOT);
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         vector_base_out <= '0;
      end else begin
         vector_base_out <= vsel_reg ? '0 : {eff_boot, 8'h00};
      end
   end

   // refused flag: a new refusal beats a same-cycle software clear
   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         refused_sticky_reg <= 1'b0;
      end else if (cpu_st_in.valid && !st_permit) begin
         refused_sticky_reg <= 1'b1;
      end else if (wr_fire && (aw_addr_reg == fsw_pkg::REG_STATUS) && w_strb_reg[0] &&
                   w_data_reg[fsw_pkg::ST_REFUSED]) begin
         refused_sticky_reg <= 1'b0;
      end
   end

   // axi4-lite write: address and data taken in any order, one at a time
   assign wr_fire = !s_axi_awready_out && !s_axi_wready_out && !s_axi_bvalid_out;

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         s_axi_awready_out <= 1'b1;
         aw_addr_reg <= '0;
      end else if (s_axi_awready_out && s_axi_awvalid_in) begin
         s_axi_awready_out <= 1'b0;
         aw_addr_reg <= s_axi_awaddr_in;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
         s_axi_awready_out <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         s_axi_wready_out <= 1'b1;
         w_data_reg <= '0;
         w_strb_reg <= '0;
      end else if (s_axi_wready_out && s_axi_wvalid_in) begin
         s_axi_wready_out <= 1'b0;
         w_data_reg <= s_axi_wdata_in;
         w_strb_reg <= s_axi_wstrb_in;
      end else if (s_axi_bvalid_out && s_axi_bready_in) begin
         s_axi_wready_out <= 1'b1;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         s_axi_bvalid_out <= 1'b0;
         s_axi_bresp_out <= fsw_pkg::RESP_OKAY;
      end else if (wr_fire) begin
         s_axi_bvalid_out <= 1'b1;
         s_axi_bresp_out <= (aw_addr_reg == fsw_pkg::REG_CTRL || aw_addr_reg == fsw_pkg::REG_CMD ||
            aw_addr_reg == fsw_pkg::REG_STATUS) ? fsw_pkg::RESP_OKAY : fsw_pkg::RESP_SLVERR;
      end else if (s_axi_bready_in) begin
         s_axi_bvalid_out <= 1'b0;
      end
   end

   // axi4-lite read: one-cycle answer, unmapped words read zero with slverr
   always_comb begin
      rd_word = '0;
      if (s_axi_araddr_in == fsw_pkg::REG_CTRL) begin
         rd_word[fsw_pkg::CTRL_LOCK] = boot_lock_reg;
         rd_word[fsw_pkg::CTRL_CWP] = cwp_reg;
         rd_word[fsw_pkg::CTRL_VSEL] = vsel_reg;
      end else if (s_axi_araddr_in == fsw_pkg::REG_STATUS) begin
         rd_word[fsw_pkg::ST_REFUSED] = refused_sticky_reg;
         rd_word[fsw_pkg::ST_ARMED] = lock_armed_reg;
         rd_word[fsw_pkg::ST_SEC +: 2] = pc_sec;
         rd_word[fsw_pkg::ST_BOOT +: 8] = eff_boot;
         rd_word[fsw_pkg::ST_CODE +: 8] = eff_code;
      end
   end

   always_ff @(posedge clk_sys_in) begin
      if (sys_rst_in) begin
         s_axi_arready_out <= 1'b1;
         s_axi_rvalid_out <= 1'b0;
         s_axi_rdata_out <= '0;
         s_axi_rresp_out <= fsw_pkg::RESP_OKAY;
      end else if (s_axi_arready_out && s_axi_arvalid_in) begin
         s_axi_arready_out <= 1'b0;
         s_axi_rvalid_out <= 1'b1;
         s_axi_rdata_out <= rd_word;
         s_axi_rresp_out <= (s_axi_araddr_in == fsw_pkg::REG_CTRL ||
            s_axi_araddr_in == fsw_pkg::REG_CMD || s_axi_araddr_in == fsw_pkg::REG_STATUS) ?
            fsw_pkg::RESP_OKAY : fsw_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid_out && s_axi_rready_in) begin
         s_axi_rvalid_out <= 1'b0;
         s_axi_arready_out <= 1'b1;
      end
   end

   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (sys_rst_in);

   a_boot_never_written:
      assert property (cpu_st_in.valid && !cpu_st_in.eeprom && st_sec == fsw_pkg::SEC_BOOT
         |=> st_refused_out)
      else $error("store to boot section not refused");
   a_data_code_denied:
      assert property (cpu_st_in.valid && pc_sec == fsw_pkg::SEC_DATA |=> st_refused_out)
      else $error("store from data section not refused");
   a_code_protect_hold:
      assert property (cwp_reg && cpu_st_in.valid && !cpu_st_in.eeprom &&
         st_sec == fsw_pkg::SEC_CODE |=> st_refused_out)
      else $error("protected code section updated");
   a_boot_writes_ok:
      assert property (cpu_st_in.valid && pc_sec == fsw_pkg::SEC_BOOT && !cwp_reg &&
         st_sec != fsw_pkg::SEC_BOOT |=> !st_refused_out)
      else $error("boot code store wrongly refused");
   a_code_writes_data:
      assert property (cpu_st_in.valid && pc_sec == fsw_pkg::SEC_CODE &&
         (cpu_st_in.eeprom || st_sec == fsw_pkg::SEC_DATA) |=> !st_refused_out)
      else $error("code section store to data refused");
   a_buffer_and_merge:
      assert property (st_take && !buf_clear |=> page_buf_out[$past(st_idx)] ==
         ($past(page_buf_out[st_idx]) & $past(cpu_st_in.data)))
      else $error("page buffer byte is not the and of old and new");
   a_flash_full_page:
      assert property (commit_out.valid && !commit_out.eeprom |-> commit_out.mask == '1)
      else $error("flash commit with partial page");
   a_eeprom_marked_only:
      assert property (commit_ok && buf_ee_reg |=> commit_out.mask == $past(mark_reg))
      else $error("eeprom commit mask differs from marked bytes");
   a_lock_blocks_read:
      assert property (lock_armed_reg && cpu_rd_valid_in && rd_sec == fsw_pkg::SEC_BOOT
         |=> rd_blocked_out)
      else $error("boot read not blocked under lock");
   a_vector_location:
      assert property (!sys_rst_in |=> vector_base_out ==
         ($past(vsel_reg) ? '0 : {$past(eff_boot), 8'h00}))
      else $error("vector base wrong");
endmodule // fsw_write_guard

//--- rtl/fsw_pkg.sv
// package: constants and carriers for the flash section write guard
package fsw_pkg;
   localparam int ADDR_W = 16;
   localparam int BLOCK_SHIFT = 8;
   localparam logic [16:0] FLASH_LAST = 17'h0bfff;
   localparam logic [7:0] BOOT_END_DEFAULT = 8'h00;
   localparam logic [7:0] CODE_END_DEFAULT = 8'h00;
   localparam int PAGE_BYTES = 32;
   localparam int IDX_W = 5;
   localparam int PAGE_W = ADDR_W - IDX_W;
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_CMD = 8'h04;
   localparam logic [7:0] REG_STATUS = 8'h08;
   localparam int CTRL_LOCK = 0;
   localparam int CTRL_CWP = 1;
   localparam int CTRL_VSEL = 2;
   localparam logic [2:0] CMD_WRITE = 3'h1;
   localparam logic [2:0] CMD_ERASE = 3'h2;
   localparam logic [2:0] CMD_ERWR = 3'h3;
   localparam logic [2:0] CMD_CLEAR = 3'h4;
   localparam int ST_REFUSED = 0;
   localparam int ST_ARMED = 1;
   localparam int ST_SEC = 2;
   localparam int ST_BOOT = 8;
   localparam int ST_CODE = 16;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   localparam logic [7:0] BYTE_ERASED = 8'hff;

   typedef enum logic [1:0] {SEC_BOOT, SEC_CODE, SEC_DATA} fsw_section_e;

   typedef struct packed {
      logic valid;
      logic eeprom;
      logic [ADDR_W-1:0] addr;
      logic [7:0] data;
   } fsw_store_s;

   typedef struct packed {
      logic valid;
      logic erase;
      logic write;
      logic eeprom;
      logic [PAGE_W-1:0] page;
      logic [PAGE_BYTES-1:0] mask;
   } fsw_commit_s;

   typedef logic [PAGE_BYTES-1:0][7:0] fsw_buf_t;
endpackage

//--- rtl/fsw_section_map.sv
// section classifier: effective fuses and the section an address falls in
`timescale 1ns/1ns
module fsw_section_map (
   input wire logic [7:0] boot_end_fuse_in,
   input wire logic [7:0] code_end_fuse_in,
   input wire logic [fsw_pkg::ADDR_W-1:0] addr_in,
   output fsw_pkg::fsw_section_e section_out,
   output logic [7:0] boot_end_out,
   output logic [7:0] code_end_out
);
   logic [16:0] boot_raw;
   logic [16:0] code_raw;
   logic [16:0] boot_b;
   logic [16:0] code_b;
   logic [16:0] addr_x;

   assign boot_raw = {1'b0, boot_end_fuse_in, 8'h00};
   assign code_raw = {1'b0, code_end_fuse_in, 8'h00};
   // out-of-range boundaries fall back to the fuse default
   assign boot_end_out = (boot_raw > fsw_pkg::FLASH_LAST) ?
      fsw_pkg::BOOT_END_DEFAULT : boot_end_fuse_in;
   assign code_end_out = (code_raw > fsw_pkg::FLASH_LAST) ?
      fsw_pkg::CODE_END_DEFAULT : code_end_fuse_in;
   assign boot_b = {1'b0, boot_end_out, 8'h00};
   assign code_b = {1'b0, code_end_out, 8'h00};
   assign addr_x = {1'b0, addr_in};

   always_comb begin
      if (boot_end_out == 8'h00) begin
         section_out = fsw_pkg::SEC_BOOT;
      end else if (addr_x < boot_b) begin
         section_out = fsw_pkg::SEC_BOOT;
      end else if (code_end_out == 8'h00) begin
         section_out = fsw_pkg::SEC_CODE;
      end else if (code_end_out <= boot_end_out) begin
         section_out = fsw_pkg::SEC_DATA;
      end else if (addr_x < code_b) begin
         section_out = fsw_pkg::SEC_CODE;
      end else begin
         section_out = fsw_pkg::SEC_DATA;
      end
   end
endmodule // fsw_section_map

//--- bench/fsw_cpu_model.sv
// cpu core model: program counter, page buffer stores and reads
`timescale 1ns/1ns
module fsw_cpu_model (
   input wire logic clk_sys_in,
   input wire logic st_refused_in,
   input wire logic rd_blocked_in,
   output logic [fsw_pkg::ADDR_W-1:0] cpu_pc_out,
   output fsw_pkg::fsw_store_s cpu_st_out,
   output logic cpu_rd_valid_out,
   output logic [fsw_pkg::ADDR_W-1:0] cpu_rd_addr_out
);
   initial begin
      cpu_pc_out = 16'h0000;
      cpu_st_out = '{valid: 1'b0, eeprom: 1'b0, addr: 16'h5a5a, data: 8'ha5};
      cpu_rd_valid_out = 1'b0;
      cpu_rd_addr_out = 16'ha5a5;
   end

   // software chooses where code runs; the boot section may hold the application
   task automatic set_pc(input logic [15:0] a);
      @(posedge clk_sys_in);
      cpu_pc_out <= a;
      repeat (2) @(posedge clk_sys_in);
   endtask

   // released lines flip so a stale value is never mistaken for a live one
   task automatic store(input logic ee, input logic [15:0] a, input logic [7:0] d,
         output logic r);
      @(posedge clk_sys_in);
      cpu_st_out <= '{valid: 1'b1, eeprom: ee, addr: a, data: d};
      @(posedge clk_sys_in);
      cpu_st_out <= '{valid: 1'b0, eeprom: ~ee, addr: ~a, data: ~d};
      #1 r = st_refused_in;
   endtask

   task automatic fetch(input logic [15:0] a, output logic b);
      @(posedge clk_sys_in);
      cpu_rd_valid_out <= 1'b1;
      cpu_rd_addr_out <= a;
      @(posedge clk_sys_in);
      cpu_rd_valid_out <= 1'b0;
      cpu_rd_addr_out <= ~a;
      #1 b = rd_blocked_in;
   endtask
endmodule // fsw_cpu_model

//--- bench/fsw_write_guard_tb.sv
// testbench for the flash section write guard
`timescale 1ns/1ns
module fsw_write_guard_tb;
   logic clk_sys_in = 1'b0;
   logic sys_rst_in = 1'b1;
   logic [7:0] boot_fuse = 8'h00;
   logic [7:0] code_fuse = 8'h00;
   logic [15:0] pc;
   fsw_pkg::fsw_store_s st;
   logic rd_v;
   logic [15:0] rd_a;
   logic [7:0] awaddr = 8'h00;
   logic awvalid = 1'b0;
   logic awready;
   logic [31:0] wdata = 32'h0;
   logic [3:0] wstrb = 4'h0;
   logic wvalid = 1'b0;
   logic wready;
   logic [1:0] bresp;
   logic bvalid;
   logic bready = 1'b0;
   logic [7:0] araddr = 8'h00;
   logic arvalid = 1'b0;
   logic arready;
   logic [31:0] rdata;
   logic [1:0] rresp;
   logic rvalid;
   logic rready = 1'b0;
   logic refused;
   logic blocked;
   logic [15:0] vbase;
   fsw_pkg::fsw_commit_s commit;
   fsw_pkg::fsw_buf_t pbuf;
   fsw_pkg::fsw_commit_s last_commit;
   logic [1:0] last_resp;
   int n_mismatch = 0;
   int checked = 0;

   always #5 clk_sys_in = ~clk_sys_in;

   fsw_write_guard fsw_write_guard_i (
      .clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in),
      .boot_end_fuse_in(boot_fuse), .code_end_fuse_in(code_fuse),
      .cpu_pc_in(pc), .cpu_st_in(st), .cpu_rd_valid_in(rd_v), .cpu_rd_addr_in(rd_a),
      .s_axi_awaddr_in(awaddr), .s_axi_awvalid_in(awvalid), .s_axi_awready_out(awready),
      .s_axi_wdata_in(wdata), .s_axi_wstrb_in(wstrb), .s_axi_wvalid_in(wvalid),
      .s_axi_wready_out(wready), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bvalid),
      .s_axi_bready_in(bready), .s_axi_araddr_in(araddr), .s_axi_arvalid_in(arvalid),
      .s_axi_arready_out(arready), .s_axi_rdata_out(rdata), .s_axi_rresp_out(rresp),
      .s_axi_rvalid_out(rvalid), .s_axi_rready_in(rready), .st_refused_out(refused),
      .rd_blocked_out(blocked), .vector_base_out(vbase), .commit_out(commit),
      .page_buf_out(pbuf)
   );

   fsw_cpu_model fsw_cpu_model_i (
      .clk_sys_in(clk_sys_in), .st_refused_in(refused), .rd_blocked_in(blocked),
      .cpu_pc_out(pc), .cpu_st_out(st), .cpu_rd_valid_out(rd_v), .cpu_rd_addr_out(rd_a)
   );

   task automatic stop_test();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checked++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys_in);
      awaddr <= a;
      wdata <= d;
      wstrb <= 4'hf;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys_in);
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         if (bvalid) break;
      end
      if (n == 40) begin
         chk(64'h0, 64'h1);
         stop_test();
      end
      last_resp = bresp;
      last_commit = commit;
      bready <= 1'b0;
      #1;
   endtask

   task automatic axr(input logic [7:0] a, output logic [31:0] d);
      int n;
      @(posedge clk_sys_in);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 40; n++) begin
         @(posedge clk_sys_in);
         if (arready) arvalid <= 1'b0;
         if (rvalid) break;
      end
      if (n == 40) begin
         chk(64'h0, 64'h1);
         stop_test();
      end
      d = rdata;
      last_resp = rresp;
      rready <= 1'b0;
      #1;
   endtask

   // a boundary past the last flash byte falls back to the fuse default
   function automatic logic [7:0] eff(input logic [7:0] f, input logic [7:0] dflt);
      return ({1'b0, f, 8'h00} > fsw_pkg::FLASH_LAST) ? dflt : f;
   endfunction

   function automatic logic [1:0] sec(input logic [15:0] p, input logic [7:0] b,
         input logic [7:0] c);
      if (b == 8'h00 || p < {b, 8'h00}) return 2'h0;
      if (c == 8'h00) return 2'h1;
      if (c <= b) return 2'h2;
      return (p < {c, 8'h00}) ? 2'h1 : 2'h2;
   endfunction

   function automatic fsw_pkg::fsw_commit_s cmt(input logic e, input logic w,
         input logic ee, input logic [10:0] pg, input logic [31:0] m);
      return '{valid: 1'b1, erase: e, write: w, eeprom: ee, page: pg, mask: m};
   endfunction

   // fuses are only captured under reset, so every map change needs a reset
   task automatic do_reset(input logic [7:0] b, input logic [7:0] c);
      @(posedge clk_sys_in);
      boot_fuse <= b;
      code_fuse <= c;
      sys_rst_in <= 1'b1;
      repeat (5) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      repeat (2) @(posedge clk_sys_in);
      #1 chk(vbase, {eff(b, fsw_pkg::BOOT_END_DEFAULT), 8'h00});
   endtask

   task automatic t_map();
      logic [7:0] bf [6] = '{8'h00, 8'h04, 8'h04, 8'h04, 8'hc0, 8'h04};
      logic [7:0] cf [6] = '{8'h00, 8'h00, 8'h03, 8'h08, 8'h08, 8'hc0};
      logic [15:0] pa [6] = '{16'h0000, 16'h03ff, 16'h0400, 16'h07ff, 16'h0800, 16'hbfff};
      logic [7:0] eb;
      logic [7:0] ec;
      logic [31:0] d;
      for (int i = 0; i < 6; i++) begin
         eb = eff(bf[i], fsw_pkg::BOOT_END_DEFAULT);
         ec = eff(cf[i], fsw_pkg::CODE_END_DEFAULT);
         do_reset(bf[i], cf[i]);
         for (int j = 0; j < 6; j++) begin
            fsw_cpu_model_i.set_pc(pa[j]);
            axr(fsw_pkg::REG_STATUS, d);
            chk(d[23:8], {ec, eb});
            chk(d[3:2], sec(pa[j], eb, ec));
         end
      end
      $display("section map test done");
   endtask

   task automatic t_perm();
      logic [15:0] pcs [10] = '{16'h0100, 16'h0100, 16'h0100, 16'h0100, 16'h0500,
         16'h0500, 16'h0500, 16'h0500, 16'h0900, 16'h0900};
      logic [15:0] ad [10] = '{16'h0500, 16'h0900, 16'h0010, 16'h0003, 16'h0900,
         16'h0010, 16'h0600, 16'h0003, 16'h0900, 16'h0003};
      logic [9:0] ee = 10'b1010001000;
      logic [9:0] ex = 10'b1101100100;
      logic r;
      do_reset(8'h04, 8'h08);
      for (int i = 0; i < 10; i++) begin
         fsw_cpu_model_i.set_pc(pcs[i]);
         fsw_cpu_model_i.store(ee[i], ad[i], 8'h11, r);
         chk(r, ex[i]);
      end
      $display("write permission test done");
   endtask

   task automatic t_buf();
      logic r;
      do_reset(8'h04, 8'h08);
      fsw_cpu_model_i.set_pc(16'h0100);
      fsw_cpu_model_i.store(1'b0, 16'h0903, 8'hf0, r);
      fsw_cpu_model_i.store(1'b0, 16'h0903, 8'h3c, r);
      chk(pbuf[3], 8'h30);
      chk(pbuf[2], fsw_pkg::BYTE_ERASED);
      axw(fsw_pkg::REG_CMD, {29'h0, fsw_pkg::CMD_WRITE});
      chk(last_commit, cmt(1'b0, 1'b1, 1'b0, 11'h048, 32'hffffffff));
      chk(pbuf[3], fsw_pkg::BYTE_ERASED);
      for (int k = 1; k < 4; k++) begin
         fsw_cpu_model_i.store(1'b1, 16'h0002, 8'h00, r);
         fsw_cpu_model_i.store(1'b1, 16'h0005, 8'h00, r);
         axw(fsw_pkg::REG_CMD, k);
         chk(last_commit, cmt(k != 1, k != 2, 1'b1, 11'h000, 32'h00000024));
      end
      fsw_cpu_model_i.store(1'b0, 16'h0901, 8'h00, r);
      axw(fsw_pkg::REG_CMD, {29'h0, fsw_pkg::CMD_CLEAR});
      chk(last_commit.valid, 1'b0);
      for (int i = 0; i < fsw_pkg::PAGE_BYTES; i++) begin
         chk(pbuf[i], fsw_pkg::BYTE_ERASED);
      end
      $display("page buffer test done");
   endtask

   task automatic t_prot();
      logic r;
      logic [31:0] d;
      do_reset(8'h04, 8'h08);
      fsw_cpu_model_i.set_pc(16'h0100);
      fsw_cpu_model_i.store(1'b0, 16'h0500, 8'h00, r);
      chk(r, 1'b0);
      axw(fsw_pkg::REG_CTRL, 32'h3);
      fsw_cpu_model_i.store(1'b0, 16'h0500, 8'h00, r);
      chk(r, 1'b1);
      axr(fsw_pkg::REG_STATUS, d);
      chk(d[0], 1'b1);
      axw(fsw_pkg::REG_STATUS, 32'h1);
      axr(fsw_pkg::REG_STATUS, d);
      chk(d[0], 1'b0);
      fsw_cpu_model_i.store(1'b0, 16'h0900, 8'h00, r);
      chk(r, 1'b0);
      fsw_cpu_model_i.fetch(16'h0010, r);
      chk(r, 1'b0);
      fsw_cpu_model_i.set_pc(16'h0500);
      axr(fsw_pkg::REG_STATUS, d);
      chk(d[1], 1'b1);
      fsw_cpu_model_i.fetch(16'h0010, r);
      chk(r, 1'b1);
      fsw_cpu_model_i.fetch(16'h0500, r);
      chk(r, 1'b0);
      fsw_cpu_model_i.set_pc(16'h0100);
      #1 chk(blocked, 1'b1);
      axw(fsw_pkg::REG_CTRL, 32'h4);
      @(posedge clk_sys_in);
      #1 chk(vbase, 16'h0000);
      axw(8'h0c, 32'h1);
      chk(last_resp, fsw_pkg::RESP_SLVERR);
      axr(8'h10, d);
      chk({d, last_resp}, {32'h0, fsw_pkg::RESP_SLVERR});
      do_reset(8'h04, 8'h08);
      fsw_cpu_model_i.set_pc(16'h0500);
      axw(fsw_pkg::REG_CTRL, 32'h1);
      axr(fsw_pkg::REG_STATUS, d);
      chk(d[1], 1'b0);
      fsw_cpu_model_i.fetch(16'h0010, r);
      chk(r, 1'b0);
      $display("lock and protect test done");
   endtask

   initial begin
      repeat (5) @(posedge clk_sys_in);
      sys_rst_in <= 1'b0;
      t_map();
      t_perm();
      t_buf();
      t_prot();
      stop_test();
   end
endmodule // fsw_write_guard_tb
